//--- common/bls_pkg.sv
// bls_pkg: register map, field layouts and loss-of-signal counts of the
// line interface status and control block.
// assumes a 200 MHz core clock and a 32-bit APB register bus.
package bls_pkg;

	// ----------------------------------------
	// clock and timing
	// ----------------------------------------
	localparam int unsigned BLS_CLK_MHZ = 200;
	localparam int unsigned BLS_LOS6312_NS = 32000;
	// least time: round up to whole cycles
	localparam int unsigned BLS_LOS6312_CYC = (BLS_LOS6312_NS * BLS_CLK_MHZ + 999) / 1000;

	// ----------------------------------------
	// register offsets (byte addresses)
	// ----------------------------------------
	localparam logic [7:0] BLS_OFS_LIVE = 8'h00;
	localparam logic [7:0] BLS_OFS_LATCHED = 8'h04;
	localparam logic [7:0] BLS_OFS_IRQ_EN = 8'h08;
	localparam logic [7:0] BLS_OFS_CTRL1 = 8'h0C;
	localparam logic [7:0] BLS_OFS_CTRL2 = 8'h10;
	localparam logic [7:0] BLS_OFS_CTRL3 = 8'h14;
	localparam logic [7:0] BLS_OFS_CTRL4 = 8'h18;
	localparam logic [7:0] BLS_OFS_MODE = 8'h1C;

	// ----------------------------------------
	// field layouts
	// ----------------------------------------
	localparam int unsigned BLS_LCS_BIT = 0;
	localparam int unsigned BLS_LBO_LSB = 0;
	localparam int unsigned BLS_TX_TERM_ON_BIT = 3;
	localparam int unsigned BLS_TX_TERM_IMPEDANCE_LSB = 4;
	localparam int unsigned BLS_RX_SENSITIVITY_SELECT_LSB = 0;
	localparam int unsigned BLS_RXMODE_LSB = 0;
	localparam int unsigned BLS_TXMODE_LSB = 2;
	localparam logic [31:0] BLS_RESET_VAL = 32'h0000_0000;

	// live status: bit0 los, bit1 short, bit2 open
	typedef struct packed {
		logic oc;
		logic sc;
		logic los;
	} bls_live_t;

	// latched status, write one to clear
	typedef struct packed {
		logic open_circuit_cleared;
		logic oc;
		logic short_circuit_cleared;
		logic sc;
		logic los;
	} bls_latch_t;

	// fourth line control register, bit6 down to bit0
	typedef struct packed {
		logic remote_loopback_en;
		logic local_loopback_en;
		logic analog_loopback_en;
		logic tx_ais_force;
		logic tx_driver_enable;
		logic tx_power_down;
		logic rx_power_down;
	} bls_ctrl4_t;

	typedef enum logic [1:0] {
		BLS_RX_DS1 = 2'b00,
		BLS_RX_E1 = 2'b01,
		BLS_RX_2048K = 2'b10,
		BLS_RX_6312K = 2'b11
	} bls_rxmode_t;

	// ----------------------------------------
	// loss-of-signal counts, in pulse intervals
	// ----------------------------------------
	localparam logic [11:0] BLS_DS1_DECL = 12'd192;
	localparam logic [11:0] BLS_DS1_WIN = 12'd192;
	localparam logic [11:0] BLS_DS1_ONES = 12'd24;
	localparam logic [11:0] BLS_DS1_ZRUN = 12'd100;
	localparam logic [11:0] BLS_E1_DECL = 12'd255;
	localparam logic [11:0] BLS_E1_WIN = 12'd255;
	localparam logic [11:0] BLS_E1_ONES = 12'd32;
	localparam logic [11:0] BLS_ETSI_DECL = 12'd2048;
	localparam logic [11:0] BLS_ETSI_ONES = 12'd1;

	localparam logic [2:0] BLS_LBO_CSU0 = 3'b101;

	function automatic logic bls_is_csu(input logic [2:0] line_build_out);
		bls_is_csu = (line_build_out >= BLS_LBO_CSU0);
	endfunction : bls_is_csu

endpackage : bls_pkg

//--- core/bls_liu_ctrl.sv
// bls_liu_ctrl: loss-of-signal detection, transmit driver gating, AIS,
// short/open circuit status, loopback steering and APB register file.
// assumes pins from the analog front end arrive asynchronously.
//
// How it works
// - DS1 declares loss after 192 intervals without a pulse.
// - DS1 clears loss on 24+ pulses per 192 and no 100-zero run.
// - loss sets the live bit and the sticky latched bit.
// - latched loss with its enable bit drives the interrupt output.
// - E1/2048k criteria 0 declares loss after 255 empty intervals.
// - criteria 0 clears loss on 32+ pulses within 255 intervals.
// - E1/2048k criteria 1 declares loss after 2048 empty intervals.
// - criteria 1 clears loss on any pulse within 255 intervals.
// - 6312k declares loss after level stays low for 32 us.
// - receiver power-down forces receive outputs low, rx pins high-z.
// - driver enabled only with hiz pin low and driver enable set.
// - forced AIS sends all ones timed by the master clock.
// - short circuit live bit, sticky rise bit and sticky fall bit.
// - each latched short/open bit with its enable raises interrupt.
// - short detection off for CSU build-out codes 101 to 111.
// - open circuit live bit, sticky rise bit and sticky fall bit.
// - open detection off for CSU build-out codes 101 to 111.
// - transmitter power-down makes both tx pins high-z.
// - waveform chosen by tx mode field plus build-out field.
// - analog, local, remote loopbacks each own control bit.
//
// Decided for this implementation: the APB register port and the register addresses.
`timescale 1ns/10ps
module bls_liu_ctrl import bls_pkg::*; #(
	parameter int unsigned LOS6312_CYC = BLS_LOS6312_CYC
) (
	input wire logic core_clk,
	input wire logic sys_rst,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic rx_clk_pin,
	input wire logic rx_pulse_pin,
	input wire logic rx_level_low_pin,
	input wire logic sc_detect_pin,
	input wire logic oc_detect_pin,
	input wire logic tx_hiz_pin,
	input wire logic tx_clk_pin,
	input wire logic bits_mclk_pin,
	input wire logic tx_data_pin,
	output logic rx_data_out,
	output logic rx_los_out,
	output logic rx_line_hiz,
	output logic tx_line_pos_o,
	output logic tx_line_pos_oe,
	output logic tx_line_neg_o,
	output logic tx_line_neg_oe,
	output logic [4:0] tx_waveform_code,
	output logic tx_term_on,
	output logic [1:0] tx_term_impedance,
	output logic [1:0] rx_sensitivity_select,
	output logic analog_loopback_en,
	output logic irq_out_pin
);

	// ----------------------------------------
	// pin synchronisers
	// ----------------------------------------
	localparam int NSYNC = 9;
	logic [NSYNC-1:0] pin_raw;
	logic [NSYNC-1:0] sync1_ff;
	logic [NSYNC-1:0] sync2_ff;
	logic rxclk_d_ff;
	logic txclk_d_ff;
	logic mclk_d_ff;

	assign pin_raw = {tx_data_pin, bits_mclk_pin, tx_clk_pin, tx_hiz_pin, oc_detect_pin,
		sc_detect_pin, rx_level_low_pin, rx_pulse_pin, rx_clk_pin};

	genvar gi;
	generate
		for (gi = 0; gi < NSYNC; gi++) begin : g_sync
			always_ff @(posedge core_clk or posedge sys_rst) begin
				if (sys_rst) begin
					sync1_ff[gi] <= 1'b0;
					sync2_ff[gi] <= 1'b0;
				end else begin
					sync1_ff[gi] <= pin_raw[gi];
					sync2_ff[gi] <= sync1_ff[gi];
				end
			end
		end
	endgenerate

	wire rxclk_s = sync2_ff[0];
	wire pulse_s = sync2_ff[1];
	wire lvl_low_s = sync2_ff[2];
	wire sc_s = sync2_ff[3];
	wire oc_s = sync2_ff[4];
	wire hiz_s = sync2_ff[5];
	wire txclk_s = sync2_ff[6];
	wire mclk_s = sync2_ff[7];
	wire txdat_s = sync2_ff[8];

	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			rxclk_d_ff <= 1'b0;
			txclk_d_ff <= 1'b0;
			mclk_d_ff <= 1'b0;
		end else begin
			rxclk_d_ff <= rxclk_s;
			txclk_d_ff <= txclk_s;
			mclk_d_ff <= mclk_s;
		end
	end

	// one pulse interval per recovered clock rising edge
	wire rx_tick = rxclk_s & ~rxclk_d_ff;
	wire tclk_tick = txclk_s & ~txclk_d_ff;
	wire mclk_tick = mclk_s & ~mclk_d_ff;

	// ----------------------------------------
	// register file
	// ----------------------------------------
	logic [31:0] lat_ff, ien_ff, ctrl1_ff, ctrl2_ff, ctrl3_ff, ctrl4_ff, mode_ff;
	logic [31:0] prdata_ff;
	logic los_ff, sc_live_ff, oc_live_ff;

	wire setup_ph = psel & ~penable;
	wire wr_acc = psel & penable & pwrite;
	wire hit_live = (paddr == BLS_OFS_LIVE);
	wire hit_lat = (paddr == BLS_OFS_LATCHED);
	wire hit_ien = (paddr == BLS_OFS_IRQ_EN);
	wire hit_c1 = (paddr == BLS_OFS_CTRL1);
	wire hit_c2 = (paddr == BLS_OFS_CTRL2);
	wire hit_c3 = (paddr == BLS_OFS_CTRL3);
	wire hit_c4 = (paddr == BLS_OFS_CTRL4);
	wire hit_md = (paddr == BLS_OFS_MODE);
	wire mapped = hit_live | hit_lat | hit_ien | hit_c1 | hit_c2 | hit_c3 | hit_c4 | hit_md;

	bls_live_t live;
	assign live = '{oc: oc_live_ff, sc: sc_live_ff, los: los_ff};

	wire [31:0] rd_mux = hit_live ? {29'h0, live} :
		hit_lat ? lat_ff : hit_ien ? ien_ff : hit_c1 ? ctrl1_ff :
		hit_c2 ? ctrl2_ff : hit_c3 ? ctrl3_ff : hit_c4 ? ctrl4_ff :
		hit_md ? mode_ff : 32'h0000_0000;

	assign pready = 1'b1;
	assign pslverr = psel & penable & ~mapped;
	assign prdata = prdata_ff;

	bls_ctrl4_t c4;
	assign c4 = bls_ctrl4_t'(ctrl4_ff[6:0]);
	wire loss_criteria_select = ctrl1_ff[BLS_LCS_BIT];
	wire [2:0] line_build_out = ctrl2_ff[BLS_LBO_LSB +: 3];
	wire [1:0] rx_mode = mode_ff[BLS_RXMODE_LSB +: 2];
	wire [1:0] tx_mode = mode_ff[BLS_TXMODE_LSB +: 2];
	wire csu = bls_is_csu(line_build_out);

	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			ien_ff <= BLS_RESET_VAL;
			ctrl1_ff <= BLS_RESET_VAL;
			ctrl2_ff <= BLS_RESET_VAL;
			ctrl3_ff <= BLS_RESET_VAL;
			ctrl4_ff <= BLS_RESET_VAL;
			mode_ff <= BLS_RESET_VAL;
			prdata_ff <= BLS_RESET_VAL;
		end else begin
			if (setup_ph) begin
				prdata_ff <= rd_mux;
			end
			if (wr_acc && hit_ien) ien_ff <= {27'h0, pwdata[4:0]};
			if (wr_acc && hit_c1) ctrl1_ff <= {31'h0, pwdata[0]};
			if (wr_acc && hit_c2) ctrl2_ff <= {26'h0, pwdata[5:0]};
			if (wr_acc && hit_c3) ctrl3_ff <= {30'h0, pwdata[1:0]};
			if (wr_acc && hit_c4) ctrl4_ff <= {25'h0, pwdata[6:0]};
			if (wr_acc && hit_md) mode_ff <= {28'h0, pwdata[3:0]};
		end
	end

	// ----------------------------------------
	// loss of signal, pulse modes
	// ----------------------------------------
	logic [11:0] zrun_ff;
	logic [11:0] win_ff;
	logic [11:0] ones_ff;
	logic longrun_ff;
	logic [12:0] lvl_cnt_ff;

	wire is_ds1 = (rx_mode == BLS_RX_DS1);
	wire is_6312 = (rx_mode == BLS_RX_6312K);
	wire [11:0] decl_cnt = is_ds1 ? BLS_DS1_DECL : (loss_criteria_select ? BLS_ETSI_DECL : BLS_E1_DECL);
	wire [11:0] win_len = is_ds1 ? BLS_DS1_WIN : BLS_E1_WIN;
	wire [11:0] ones_min = is_ds1 ? BLS_DS1_ONES : (loss_criteria_select ? BLS_ETSI_ONES : BLS_E1_ONES);
	// saturate: a mode change can leave the run above a shorter limit
	wire [11:0] zrun_nxt = pulse_s ? 12'h000 : (zrun_ff >= decl_cnt ? decl_cnt : zrun_ff + 12'h001);
	wire [11:0] ones_nxt = ones_ff + {11'h000, pulse_s};
	wire win_end = (win_ff == win_len - 12'h001);
	wire run_hit = (zrun_nxt >= BLS_DS1_ZRUN);
	wire pulse_decl = rx_tick & (zrun_nxt == decl_cnt);
	// only DS1 vetoes on long zero runs
	wire pulse_clr = rx_tick & win_end & (ones_nxt >= ones_min)
		& ~(is_ds1 & (longrun_ff | run_hit));
	wire lvl_decl = (lvl_cnt_ff == 13'(LOS6312_CYC));

	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			zrun_ff <= 12'h000;
			win_ff <= 12'h000;
			ones_ff <= 12'h000;
			longrun_ff <= 1'b0;
		end else if (rx_tick) begin
			zrun_ff <= zrun_nxt;
			win_ff <= win_end ? 12'h000 : win_ff + 12'h001;
			ones_ff <= win_end ? 12'h000 : ones_nxt;
			longrun_ff <= win_end ? 1'b0 : (longrun_ff | run_hit);
		end
	end

	// counter stops at the limit so loss stays declared while the level stays low
	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			lvl_cnt_ff <= 13'h0000;
		end else if (!lvl_low_s || !is_6312) begin
			lvl_cnt_ff <= 13'h0000;
		end else if (!lvl_decl) begin
			lvl_cnt_ff <= lvl_cnt_ff + 13'h0001;
		end
	end

	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			los_ff <= 1'b0;
		end else if (is_6312) begin
			los_ff <= lvl_decl;
		end else if (pulse_decl) begin
			los_ff <= 1'b1;
		end else if (pulse_clr) begin
			los_ff <= 1'b0;
		end
	end

	// ----------------------------------------
	// short/open circuit live and latched status
	// ----------------------------------------
	logic sc_prev_ff, oc_prev_ff;
	wire sc_live_nxt = sc_s & ~csu;
	wire oc_live_nxt = oc_s & ~csu;

	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			sc_live_ff <= 1'b0;
			oc_live_ff <= 1'b0;
			sc_prev_ff <= 1'b0;
			oc_prev_ff <= 1'b0;
		end else begin
			sc_live_ff <= sc_live_nxt;
			oc_live_ff <= oc_live_nxt;
			sc_prev_ff <= sc_live_ff;
			oc_prev_ff <= oc_live_ff;
		end
	end

	logic los_prev_ff;
	bls_latch_t evt;
	assign evt = '{open_circuit_cleared: oc_prev_ff & ~oc_live_ff, oc: oc_live_ff & ~oc_prev_ff,
		short_circuit_cleared: sc_prev_ff & ~sc_live_ff, sc: sc_live_ff & ~sc_prev_ff,
		los: los_ff & ~los_prev_ff};
	wire [4:0] w1c = (wr_acc && hit_lat) ? pwdata[4:0] : 5'h00;

	// a new event wins over a clear in the same cycle
	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			lat_ff <= BLS_RESET_VAL;
			los_prev_ff <= 1'b0;
		end else begin
			los_prev_ff <= los_ff;
			lat_ff <= {27'h0, (lat_ff[4:0] & ~w1c) | evt};
		end
	end

	assign irq_out_pin = |(lat_ff[4:0] & ien_ff[4:0]);

	// ----------------------------------------
	// receive outputs and loopbacks
	// ----------------------------------------
	logic rx_data_ff;
	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			rx_data_ff <= 1'b0;
		end else if (c4.rx_power_down) begin
			rx_data_ff <= 1'b0;
		end else if (c4.local_loopback_en) begin
			rx_data_ff <= txdat_s;
		end else if (rx_tick) begin
			rx_data_ff <= pulse_s;
		end
	end

	assign rx_data_out = rx_data_ff;
	assign rx_los_out = los_ff & ~c4.rx_power_down;
	assign rx_line_hiz = c4.rx_power_down;
	assign analog_loopback_en = c4.analog_loopback_en;

	// ----------------------------------------
	// transmit path
	// ----------------------------------------
	logic pos_ff, neg_ff, pol_ff;
	wire tx_tick = c4.tx_ais_force ? mclk_tick : tclk_tick;
	wire tx_src = c4.remote_loopback_en ? rx_data_ff : txdat_s;
	wire tx_bit = c4.tx_ais_force | tx_src;

	// marks alternate polarity so the line stays balanced
	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			pos_ff <= 1'b0;
			neg_ff <= 1'b0;
			pol_ff <= 1'b0;
		end else if (tx_tick) begin
			pos_ff <= tx_bit & ~pol_ff;
			neg_ff <= tx_bit & pol_ff;
			pol_ff <= pol_ff ^ tx_bit;
		end
	end

	wire drv_en = ~hiz_s & c4.tx_driver_enable & ~c4.tx_power_down;
	assign tx_line_pos_o = pos_ff;
	assign tx_line_neg_o = neg_ff;
	assign tx_line_pos_oe = drv_en;
	assign tx_line_neg_oe = drv_en;
	assign tx_waveform_code = {tx_mode, line_build_out};
	// termination is switched on by CTRL2 bit 3, off after reset; software must program it
	assign tx_term_on = ctrl2_ff[BLS_TX_TERM_ON_BIT];
	assign tx_term_impedance = ctrl2_ff[BLS_TX_TERM_IMPEDANCE_LSB +: 2];
	assign rx_sensitivity_select = ctrl3_ff[BLS_RX_SENSITIVITY_SELECT_LSB +: 2];

	// ----------------------------------------
	// assertions
	// ----------------------------------------
	a_irq_follows: assert property (@(posedge core_clk) disable iff (sys_rst)
		($rose(los_ff) && ien_ff[0]) |=> (!ien_ff[0] || irq_out_pin))
		else $error("irq low after enabled loss event");
	a_los_declare: assert property (@(posedge core_clk) disable iff (sys_rst)
		(!is_6312 && rx_tick && !pulse_s && zrun_ff == decl_cnt - 12'h001) |=> los_ff)
		else $error("loss not declared at count");
	a_los_latch: assert property (@(posedge core_clk) disable iff (sys_rst)
		$rose(los_ff) |=> lat_ff[0])
		else $error("latched loss not set");
	a_tx_hiz_gate: assert property (@(posedge core_clk) disable iff (sys_rst)
		(hiz_s || !c4.tx_driver_enable) |-> !tx_line_pos_oe && !tx_line_neg_oe)
		else $error("driver on while disabled");
	a_tpd_hiz: assert property (@(posedge core_clk) disable iff (sys_rst)
		c4.tx_power_down |-> !tx_line_pos_oe && !tx_line_neg_oe)
		else $error("driver on in power down");
	a_rpd_low: assert property (@(posedge core_clk) disable iff (sys_rst)
		c4.rx_power_down && $past(c4.rx_power_down) |-> !rx_data_out && !rx_los_out)
		else $error("receive output high in power down");
	a_csu_no_sc: assert property (@(posedge core_clk) disable iff (sys_rst)
		csu && $past(csu) |-> !sc_live_ff && !oc_live_ff)
		else $error("circuit detection active in csu");
	a_scc_latch: assert property (@(posedge core_clk) disable iff (sys_rst)
		$fell(sc_live_ff) |=> lat_ff[2])
		else $error("short cleared not latched");
	a_occ_latch: assert property (@(posedge core_clk) disable iff (sys_rst)
		$fell(oc_live_ff) |=> lat_ff[4])
		else $error("open cleared not latched");
	a_ais_ones: assert property (@(posedge core_clk) disable iff (sys_rst)
		(c4.tx_ais_force && mclk_tick) |=> (tx_line_pos_o ^ tx_line_neg_o))
		else $error("ais mark missing");
	a_lvl_declare: assert property (@(posedge core_clk) disable iff (sys_rst)
		(is_6312 && lvl_decl) |=> los_ff)
		else $error("6312k loss not declared");

endmodule : bls_liu_ctrl

//--- test/bls_line_model.sv
// bls_line_model: far end of the receive line, one pulse interval per eight
// core cycles with a pulse every pulse_period intervals (0 gives a dead line).
// assumes core_clk and sys_rst come from the bench.
`timescale 1ns/10ps
module bls_line_model (
	input wire logic core_clk,
	input wire logic sys_rst,
	input wire logic [7:0] pulse_period,
	output logic rx_clk_pin,
	output logic rx_pulse_pin
);
	// ----------------------------------------
	// interval generator
	// ----------------------------------------
	logic [2:0] ph_ff;
	logic [7:0] iv_ff;
	// pulse level moves at phase 7, far from the clock rise near phase 5
	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			ph_ff <= 3'h0;
			iv_ff <= 8'h00;
			rx_clk_pin <= 1'b0;
			rx_pulse_pin <= 1'b0;
		end else begin
			ph_ff <= ph_ff + 3'h1;
			rx_clk_pin <= ph_ff[2];
			if (ph_ff == 3'h7) begin
				iv_ff <= (iv_ff + 8'h01 >= pulse_period) ? 8'h00 : iv_ff + 8'h01;
				rx_pulse_pin <= (pulse_period != 8'h00) && (iv_ff == 8'h00);
			end
		end
	end
endmodule : bls_line_model

//--- test/bls_liu_ctrl_tb_top.sv
// bls_liu_ctrl_tb_top: APB-driven tests of loss detection, status and tx gating.
// assumes the line model feeds the receive pins; the 6312k count is cut to 20.
`timescale 1ns/10ps
module bls_liu_ctrl_tb_top import bls_pkg::*; ;
	logic core_clk = 1'b0, sys_rst = 1'b1;
	logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [7:0] paddr = 8'h00, period = 8'h01;
	logic [31:0] pwdata = 32'h0000_0000, prdata, rd;
	logic pready, pslverr, err, rx_clk_pin, rx_pulse_pin;
	logic rx_level_low_pin = 1'b0, sc_detect_pin = 1'b0, oc_detect_pin = 1'b0;
	logic tx_hiz_pin = 1'b0, tx_clk_pin = 1'b0, bits_mclk_pin = 1'b0, tx_data_pin = 1'b0;
	logic tx_run = 1'b0;
	logic [3:0] cnt_ff = 4'h0;
	logic rx_data_out, rx_los_out, rx_line_hiz, tx_line_pos_o, tx_line_pos_oe;
	logic tx_line_neg_o, tx_line_neg_oe, tx_term_on, analog_loopback_en, irq_out_pin;
	logic [4:0] tx_waveform_code;
	logic [1:0] tx_term_impedance, rx_sensitivity_select;
	int n_fail = 0, num_checks = 0, n;

	bls_liu_ctrl #(.LOS6312_CYC(20)) dut_u (
		.core_clk, .sys_rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
		.pslverr, .rx_clk_pin, .rx_pulse_pin, .rx_level_low_pin, .sc_detect_pin,
		.oc_detect_pin, .tx_hiz_pin, .tx_clk_pin, .bits_mclk_pin, .tx_data_pin, .rx_data_out,
		.rx_los_out, .rx_line_hiz, .tx_line_pos_o, .tx_line_pos_oe, .tx_line_neg_o,
		.tx_line_neg_oe, .tx_waveform_code, .tx_term_on, .tx_term_impedance,
		.rx_sensitivity_select, .analog_loopback_en, .irq_out_pin
	);
	bls_line_model line_u (.core_clk, .sys_rst, .pulse_period(period), .rx_clk_pin,
		.rx_pulse_pin);

	initial begin
		forever #2.5 core_clk = ~core_clk;
	end
	// master clock every 8 cycles, tx clock every 16 and only while tx_run
	always @(posedge core_clk) begin
		cnt_ff <= cnt_ff + 4'h1;
		bits_mclk_pin <= cnt_ff[2];
		tx_clk_pin <= tx_run & cnt_ff[3];
	end

	// ----------------------------------------
	// tasks
	// ----------------------------------------
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			n_fail++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk

	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		@(posedge core_clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge core_clk);
		penable <= 1'b1;
		@(posedge core_clk);
		while (pready !== 1'b1) @(posedge core_clk);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	task automatic rc(input logic [7:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h0000_0000);
		chk(rd, e);
		chk(32'(err), 32'(a > BLS_OFS_MODE));
	endtask : rc

	// sample a step after the edge so its updates have landed
	task automatic wt(input int c);
		repeat (c) @(posedge core_clk);
		#1;
	endtask : wt

	task automatic pin(input int k, input logic v);
		@(posedge core_clk);
		if (k == 0) sc_detect_pin <= v;
		else oc_detect_pin <= v;
		wt(6);
	endtask : pin

	task automatic marks;
		logic p, q;
		n = 0;
		p = tx_line_pos_o;
		q = tx_line_neg_o;
		repeat (200) begin
			wt(1);
			if (tx_line_pos_o !== p) n++;
			if (tx_line_neg_o !== q) n++;
			p = tx_line_pos_o;
			q = tx_line_neg_o;
		end
	endtask : marks

	task automatic los_set(input int no, input int yes);
		@(posedge core_clk) period <= 8'h00;
		wt(no * 8);
		chk(32'(rx_los_out), 32'h0);
		wt(yes * 8);
		chk(32'(rx_los_out), 32'h1);
	endtask : los_set

	// free-running windows: allow a partial one plus a whole one per phase
	task automatic los_clr(input logic [7:0] ps, input logic [7:0] pc, input int win);
		@(posedge core_clk) period <= ps;
		wt(win * 8);
		chk(32'(rx_los_out), 32'h1);
		@(posedge core_clk) period <= pc;
		wt(win * 8);
		chk(32'(rx_los_out), 32'h0);
	endtask : los_clr

	task automatic end_sim;
		$display("checks=%0d failures=%0d", num_checks, n_fail);
		if (n_fail == 0 && num_checks > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask : end_sim

	// ----------------------------------------
	// tests
	// ----------------------------------------
	initial begin
		repeat (90000) @(posedge core_clk);
		n_fail++;
		end_sim();
	end

	initial begin
		repeat (12) @(posedge core_clk);
		sys_rst <= 1'b0;
		for (int i = 0; i < 8; i++) begin
			rc(8'(4 * i), 32'h0000_0000);
		end
		rc(8'h20, 32'h0000_0000);
		chk(32'(err), 32'h0000_0001);
		apb(1'b1, BLS_OFS_MODE, 32'h0000_0008);
		apb(1'b1, BLS_OFS_CTRL2, 32'h0000_002B);
		apb(1'b1, BLS_OFS_CTRL3, 32'h0000_0002);
		apb(1'b1, BLS_OFS_CTRL4, 32'h0000_0070);
		wt(4);
		chk(32'(tx_waveform_code), 32'h0000_0013);
		chk(32'({tx_term_on, tx_term_impedance, rx_sensitivity_select, analog_loopback_en}),
			32'h0000_0035);
		rc(BLS_OFS_CTRL4, 32'h0000_0070);
		for (int i = 0; i < 8; i++) begin
			@(posedge core_clk) tx_hiz_pin <= i[2];
			apb(1'b1, BLS_OFS_CTRL4, {29'h0, i[1], i[0], 1'b0});
			wt(4);
			chk(32'({tx_line_pos_oe, tx_line_neg_oe}),
				{30'h0, {2{i[1] & ~i[0] & ~i[2]}}});
		end
		@(posedge core_clk) tx_run <= 1'b1;
		marks();
		chk(32'(n), 32'h0000_0000);
		@(posedge core_clk) tx_run <= 1'b0;
		apb(1'b1, BLS_OFS_CTRL4, 32'h0000_0008);
		marks();
		chk(32'(n >= 44 && n <= 54), 32'h0000_0001);
		apb(1'b1, BLS_OFS_CTRL4, 32'h0000_0040);
		@(posedge core_clk) tx_run <= 1'b1;
		marks();
		chk(32'(n >= 20 && n <= 28), 32'h0000_0001);
		@(posedge core_clk) tx_run <= 1'b0;
		apb(1'b1, BLS_OFS_CTRL4, 32'h0000_0000);
		for (int k = 0; k < 2; k++) begin
			apb(1'b1, BLS_OFS_CTRL2, 32'h0000_0004);
			apb(1'b1, BLS_OFS_IRQ_EN, 32'(2 << (2 * k)));
			pin(k, 1'b1);
			rc(BLS_OFS_LIVE, 32'(2 << k));
			rc(BLS_OFS_LATCHED, 32'(2 << (2 * k)));
			chk(32'(irq_out_pin), 32'h0000_0001);
			pin(k, 1'b0);
			rc(BLS_OFS_LIVE, 32'h0000_0000);
			rc(BLS_OFS_LATCHED, 32'(6 << (2 * k)));
			apb(1'b1, BLS_OFS_LATCHED, 32'(2 << (2 * k)));
			wt(2);
			chk(32'(irq_out_pin), 32'h0000_0000);
			rc(BLS_OFS_LATCHED, 32'(4 << (2 * k)));
			apb(1'b1, BLS_OFS_LATCHED, 32'h0000_001F);
			for (int b = 5; b < 8; b++) begin
				apb(1'b1, BLS_OFS_CTRL2, 32'(b));
				pin(k, 1'b1);
				rc(BLS_OFS_LIVE, 32'h0000_0000);
				rc(BLS_OFS_LATCHED, 32'h0000_0000);
				pin(k, 1'b0);
			end
		end
		apb(1'b1, BLS_OFS_CTRL2, 32'h0000_0000);
		apb(1'b1, BLS_OFS_IRQ_EN, 32'h0000_0001);
		los_set(180, 20);
		rc(BLS_OFS_LIVE, 32'h0000_0001);
		rc(BLS_OFS_LATCHED, 32'h0000_0001);
		chk(32'(irq_out_pin), 32'h0000_0001);
		@(posedge core_clk) tx_data_pin <= 1'b1;
		apb(1'b1, BLS_OFS_CTRL4, 32'h0000_0020);
		wt(4);
		chk(32'(rx_data_out), 32'h0000_0001);
		apb(1'b1, BLS_OFS_CTRL4, 32'h0000_0021);
		wt(2);
		chk(32'({rx_los_out, rx_data_out, rx_line_hiz}), 32'h0000_0001);
		apb(1'b1, BLS_OFS_CTRL4, 32'h0000_0000);
		los_clr(8'd10, 8'd1, 400);
		chk(32'(irq_out_pin), 32'h0000_0001);
		apb(1'b1, BLS_OFS_LATCHED, 32'h0000_0001);
		wt(2);
		chk(32'(irq_out_pin), 32'h0000_0000);
		apb(1'b1, BLS_OFS_MODE, 32'h0000_0001);
		los_set(240, 30);
		los_clr(8'd10, 8'd7, 600);
		apb(1'b1, BLS_OFS_MODE, 32'h0000_0002);
		apb(1'b1, BLS_OFS_CTRL1, 32'h0000_0001);
		los_set(2000, 100);
		los_clr(8'd0, 8'd200, 600);
		apb(1'b1, BLS_OFS_MODE, 32'h0000_0003);
		@(posedge core_clk) rx_level_low_pin <= 1'b1;
		wt(12);
		chk(32'(rx_los_out), 32'h0000_0000);
		wt(20);
		chk(32'(rx_los_out), 32'h0000_0001);
		@(posedge core_clk) rx_level_low_pin <= 1'b0;
		wt(8);
		chk(32'(rx_los_out), 32'h0000_0000);
		end_sim();
	end
endmodule : bls_liu_ctrl_tb_top
